// file: seb_eeprom.sv
`timescale 1ns/1ps

`include "seb_regs.svh"

module seb_eeprom #(
	parameter logic [3:0]  TYPE_CODE   = 4'h6,
	parameter int unsigned PROG_CYCLES = `SEB_TWR_MS * `SEB_REF_KHZ
) (
	// Core clock and reset.
	input  wire logic ref_clk,
	input  wire logic arst_n,
	// Link-side sampling clock.
	input  wire logic bus_sample_clk,
	// Two-wire bus pins.
	input  wire logic scl_pin,
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	// Write protect pin.
	input  wire logic wp_pin,
	// Status.
	output logic      standby,
	output logic      prog_busy
);

	// TYPE_CODE default value is arbitrary.

	seb_pkg::seb_link_t l;
	seb_pkg::seb_link_t next_l;

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic busy_now;

	seb_mem_if #(.AW(`SEB_ADDR_W), .DW(`SEB_DATA_W)) mem ();
	seb_prog_if                                      prog ();

	////////////////////////////////////////////////////////////////////////////////
	// Storage array on the link clock, so reads never cross domains.
	// Full array
	seb_array #(
		.DEPTH (`SEB_ARRAY_BYTES),
		.AW    (`SEB_ADDR_W),
		.DW    (`SEB_DATA_W)
	) u_array (
		.clk  (bus_sample_clk),
		.port (mem.mem)
	);

	// Programming timer runs on the core clock; only toggles cross.
	seb_prog_timer #(
		.PROG_CYCLES (PROG_CYCLES)
	) u_timer (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.prog    (prog.core)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus events, seen only after the two-flop synchronisers.
	always_comb
	begin
		scl_rise  = l.scl_s & ~l.scl_q;
		scl_fall  = ~l.scl_s & l.scl_q;
		bus_start = l.scl_s & l.scl_q & l.sda_q & ~l.sda_s;
		bus_stop  = l.scl_s & l.scl_q & ~l.sda_q & l.sda_s;
		busy_now  = l.req_tog != l.ack_s;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state of the bus engine.
	always_comb
	begin
		next_l        = l;
		next_l.scl_m  = scl_pin;
		next_l.scl_s  = l.scl_m;
		next_l.scl_q  = l.scl_s;
		next_l.sda_m  = sda_i;
		next_l.sda_s  = l.sda_m;
		next_l.sda_q  = l.sda_s;
		next_l.wp_m   = wp_pin;
		next_l.wp_s   = l.wp_m;
		next_l.ack_m  = prog.ack_tog;
		next_l.ack_s  = l.ack_m;
		next_l.mem_we = 1'b0;
		next_l.sda_o  = `SEB_SDA_LOW;

		case (l.state)
			seb_pkg::SEB_IDLE:
			begin
				// Nothing happens until a Start is seen.
				next_l.sda_oe = 1'b0;
			end

			seb_pkg::SEB_ADDR, seb_pkg::SEB_WORD, seb_pkg::SEB_DATA:
			begin
				// Bits are taken on the rising clock, MSB first.
				if (scl_rise)
				begin
					next_l.shreg = {l.shreg[6:0], l.sda_s};
					next_l.cnt   = l.cnt + 4'h1;
				end
				else if (scl_fall && l.cnt == `SEB_BYTE_BITS)
				begin
					next_l.cnt    = 4'h0;
					next_l.state  = seb_pkg::SEB_ACK;
					next_l.sda_oe = 1'b1;
					if (l.state == seb_pkg::SEB_ADDR)
					begin
						if (l.shreg[7:4] == TYPE_CODE)
						begin
							next_l.blk = l.shreg[3:1];
							if (l.shreg[0] == `SEB_DIR_READ)
							begin
								next_l.ret = seb_pkg::SEB_TX;
							end
							else
							begin
								next_l.ret = seb_pkg::SEB_WORD;
							end
						end
						else
						begin
							// Foreign address: stay silent until next Start.
							next_l.state  = seb_pkg::SEB_IDLE;
							next_l.sda_oe = 1'b0;
						end
					end
					else if (l.state == seb_pkg::SEB_WORD)
					begin
						next_l.ptr = {l.blk, l.shreg};
						next_l.ret = seb_pkg::SEB_DATA;
					end
					else if (l.wp_s)
					begin
						next_l.state  = seb_pkg::SEB_IDLE;
						next_l.sda_oe = 1'b0;
					end
					else
					begin
						next_l.pbuf[l.ptr[3:0]]  = l.shreg;
						next_l.pmask[l.ptr[3:0]] = 1'b1;
						next_l.wr_pend           = 1'b1;
						next_l.ptr = {l.ptr[`SEB_ADDR_W-1:4], l.ptr[3:0] + 4'h1};
						next_l.ret = seb_pkg::SEB_DATA;
					end
				end
			end

			seb_pkg::SEB_ACK:
			begin
				if (scl_fall)
				begin
					next_l.sda_oe = 1'b0;
					next_l.state  = l.ret;
					if (l.ret == seb_pkg::SEB_TX)
					begin
						next_l.shreg  = mem.rdata;
						next_l.sda_oe = ~mem.rdata[7];
						next_l.ptr    = l.ptr + `SEB_ADDR_W'(1);
					end
				end
			end

			seb_pkg::SEB_TX:
			begin
				// Data changes only while the clock is low.
				if (scl_rise)
				begin
					next_l.cnt = l.cnt + 4'h1;
				end
				else if (scl_fall)
				begin
					if (l.cnt == `SEB_BYTE_BITS)
					begin
						next_l.cnt    = 4'h0;
						next_l.sda_oe = 1'b0;
						next_l.state  = seb_pkg::SEB_RACK;
					end
					else
					begin
						next_l.shreg  = {l.shreg[6:0], 1'b0};
						next_l.sda_oe = ~l.shreg[6];
					end
				end
			end

			seb_pkg::SEB_RACK:
			begin
				if (scl_rise)
				begin
					if (l.sda_s)
					begin
						next_l.state = seb_pkg::SEB_IDLE;
					end
					else
					begin
						next_l.state = seb_pkg::SEB_ACK;
						next_l.ret   = seb_pkg::SEB_TX;
					end
				end
			end

			seb_pkg::SEB_COPY:
			begin
				next_l.mem_we    = l.pmask[l.copy_idx];
				next_l.mem_waddr = {l.ptr[`SEB_ADDR_W-1:4], l.copy_idx};
				next_l.mem_wdata = l.pbuf[l.copy_idx];
				next_l.copy_idx  = l.copy_idx + 4'h1;
				if (l.copy_idx == `SEB_PAGE_LAST)
				begin
					next_l.pmask = '0;
					next_l.state = seb_pkg::SEB_IDLE;
				end
			end

			default:
			begin
				next_l.state = seb_pkg::SEB_IDLE;
			end
		endcase

		// Start and Stop take priority; the page copy is short and is not cut.
		if (l.state != seb_pkg::SEB_COPY)
		begin
			if (bus_start)
			begin
				next_l.sda_oe  = 1'b0;
				next_l.cnt     = 4'h0;
				next_l.wr_pend = 1'b0;
				next_l.pmask   = '0;
				if (busy_now)
				begin
					next_l.state = seb_pkg::SEB_IDLE;
				end
				else
				begin
					next_l.state = seb_pkg::SEB_ADDR;
				end
			end
			else if (bus_stop)
			begin
				next_l.sda_oe = 1'b0;
				next_l.state  = seb_pkg::SEB_IDLE;
				if (l.wr_pend)
				begin
					next_l.state    = seb_pkg::SEB_COPY;
					next_l.copy_idx = 4'h0;
					next_l.wr_pend  = 1'b0;
					next_l.req_tog  = ~l.req_tog;
				end
			end
		end

		// Standby when idle and not programming
		next_l.busy    = next_l.req_tog != l.ack_s;
		next_l.standby = (next_l.state == seb_pkg::SEB_IDLE) && !next_l.busy;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Single register for the whole link-side state.
	always_ff @(posedge bus_sample_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			l <= '0;
		end
		else
		begin
			l <= next_l;
		end
	end

	// Interface and pin outputs, each straight from the state register.
	assign mem.we       = l.mem_we;
	assign mem.waddr    = l.mem_waddr;
	assign mem.wdata    = l.mem_wdata;
	assign mem.raddr    = l.ptr;
	assign prog.req_tog = l.req_tog;
	assign sda_o        = l.sda_o;
	assign sda_oe       = l.sda_oe;
	assign standby      = l.standby;
	assign prog_busy    = l.busy;

endmodule : seb_eeprom

// file: seb_regs.svh
`ifndef SEB_REGS_SVH
`define SEB_REGS_SVH

// Array geometry.
`define SEB_ADDR_W      11
`define SEB_DATA_W      8
`define SEB_ARRAY_BYTES 2048
`define SEB_PAGE_LAST   4'hf

// Byte framing on the two-wire bus.
`define SEB_BYTE_BITS   4'h8
`define SEB_DIR_READ    1'b1

// Self-timed programming cycle, in milliseconds, and the core clock in kHz.
`define SEB_TWR_MS      5
`define SEB_REF_KHZ     125000
`define SEB_TCNT_W      24

// Idle level of the open-drain data output.
`define SEB_SDA_LOW     1'b0

`endif

// file: seb_pkg.sv
package seb_pkg;

`include "seb_regs.svh"

	// Bus engine states, Gray coded along address, ack, word, data.
	typedef enum logic [2:0]
	{
		SEB_IDLE = 3'h0,
		SEB_ADDR = 3'h1,
		SEB_ACK  = 3'h3,
		SEB_WORD = 3'h2,
		SEB_DATA = 3'h6,
		SEB_TX   = 3'h7,
		SEB_RACK = 3'h5,
		SEB_COPY = 3'h4
	} seb_state_t;

	// Whole state of the link-side bus engine.
	typedef struct packed {
		logic                    scl_m;
		logic                    scl_s;
		logic                    scl_q;
		logic                    sda_m;
		logic                    sda_s;
		logic                    sda_q;
		logic                    wp_m;
		logic                    wp_s;
		logic                    ack_m;
		logic                    ack_s;
		seb_state_t              state;
		seb_state_t              ret;
		logic [3:0]              cnt;
		logic [7:0]              shreg;
		logic [2:0]              blk;
		logic [`SEB_ADDR_W-1:0]  ptr;
		logic [15:0][7:0]        pbuf;
		logic [15:0]             pmask;
		logic                    wr_pend;
		logic [3:0]              copy_idx;
		logic                    req_tog;
		logic                    busy;
		logic                    standby;
		logic                    sda_oe;
		logic                    sda_o;
		logic                    mem_we;
		logic [`SEB_ADDR_W-1:0]  mem_waddr;
		logic [`SEB_DATA_W-1:0]  mem_wdata;
	} seb_link_t;

	// State of the programming-cycle timer on the core clock.
	typedef struct packed {
		logic                    req_m;
		logic                    req_s;
		logic [`SEB_TCNT_W-1:0]  cnt;
		logic                    ack;
	} seb_timer_t;

endpackage : seb_pkg

// file: seb_if.sv
`timescale 1ns/1ps

// Array access between the bus engine and the storage array.
interface seb_mem_if #(
	parameter int AW = 11,
	parameter int DW = 8
);
	logic          we;
	logic [AW-1:0] waddr;
	logic [DW-1:0] wdata;
	logic [AW-1:0] raddr;
	logic [DW-1:0] rdata;

	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : seb_mem_if

// Toggle handshake that launches and ends a programming cycle.
interface seb_prog_if;
	logic req_tog;
	logic ack_tog;

	modport link (output req_tog, input ack_tog);
	modport core (input req_tog, output ack_tog);
endinterface : seb_prog_if

// file: seb_array.sv
`timescale 1ns/1ps

`include "seb_regs.svh"

// Storage array with one write port and a registered read port.
module seb_array #(
	parameter int DEPTH = `SEB_ARRAY_BYTES,
	parameter int AW    = `SEB_ADDR_W,
	parameter int DW    = `SEB_DATA_W
) (
	// Clock of the bus engine.
	input  wire logic clk,
	// Access port.
	seb_mem_if.mem    port
);

	logic [DW-1:0] cells [DEPTH];
	logic [DW-1:0] rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Cells have no reset: their content is what the last programming cycle left.
	always_ff @(posedge clk)
	begin
		if (port.we)
		begin
			cells[port.waddr] <= port.wdata;
		end
		rdata <= cells[port.raddr];
	end

	assign port.rdata = rdata;

endmodule : seb_array

// file: seb_prog_timer.sv
`timescale 1ns/1ps

`include "seb_regs.svh"

// Times the self-timed programming cycle on the core clock.
module seb_prog_timer #(
	parameter int unsigned PROG_CYCLES = `SEB_TWR_MS * `SEB_REF_KHZ
) (
	// Core clock and reset.
	input  wire logic ref_clk,
	input  wire logic arst_n,
	// Handshake with the bus engine.
	seb_prog_if.core  prog
);

	localparam logic [`SEB_TCNT_W-1:0] CNT_LAST = `SEB_TCNT_W'(PROG_CYCLES - 1);

	seb_pkg::seb_timer_t t;
	seb_pkg::seb_timer_t next_t;

	////////////////////////////////////////////////////////////////////////////////
	// A request toggle differing from the ack toggle means a cycle is running.
	always_comb
	begin
		next_t       = t;
		next_t.req_m = prog.req_tog;
		next_t.req_s = t.req_m;
		if (t.req_s != t.ack)
		begin
			if (t.cnt == CNT_LAST)
			begin
				next_t.cnt = '0;
				next_t.ack = t.req_s;
			end
			else
			begin
				next_t.cnt = t.cnt + `SEB_TCNT_W'(1);
			end
		end
	end

	// Single register for the whole timer state.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			t <= '0;
		end
		else
		begin
			t <= next_t;
		end
	end

	assign prog.ack_tog = t.ack;

endmodule : seb_prog_timer

// file: seb_eeprom_properties.sv
`timescale 1ns/1ps

// Watches the bus pins and status outputs of the slave.
module seb_eeprom_props #(
	parameter int unsigned PROG_CYCLES = 625000
) (
	// Link clock and reset.
	input wire logic bus_sample_clk,
	input wire logic arst_n,
	// Bus and status.
	input wire logic scl_pin,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic standby,
	input wire logic prog_busy
);
	// Core cycles of 8 ns seen as link cycles of 6 ns, with slack for the syncs.
	localparam int MIN_BUSY = PROG_CYCLES * 4 / 3 - 8;
	localparam int MAX_BUSY = PROG_CYCLES * 4 / 3 + 64;
	logic [23:0] busy_cnt;

	default clocking cb @(posedge bus_sample_clk); endclocking
	default disable iff (!arst_n);

	// Length of the running programming cycle.
	always_ff @(posedge bus_sample_clk or negedge arst_n)
	begin
		if (!arst_n)
			busy_cnt <= '0;
		else
			busy_cnt <= prog_busy ? busy_cnt + 24'h1 : '0;
	end

	drain_low_a: assert property (sda_o == 1'b0) else $error("data output not low");
	oe_on_low_a: assert property ($changed(sda_oe) |-> !$past(scl_pin, 2)) else $error("drive moved in clock high");
	busy_excl_a: assert property (!(standby && prog_busy)) else $error("standby while programming");
	reset_idle_a: assert property ($rose(arst_n) |-> ##[0:2] standby) else $error("no standby after reset");
	idle_quiet_a: assert property (standby |-> !sda_oe) else $error("drive in standby");
	stop_launch_a: assert property ($rose(prog_busy) |-> $past(scl_pin, 3) && scl_pin && sda_i)
		else $error("programming without stop");
	busy_len_a: assert property ($fell(prog_busy) |-> $past(busy_cnt) >= MIN_BUSY && $past(busy_cnt) <= MAX_BUSY)
		else $error("programming time wrong");
	busy_deaf_a: assert property (prog_busy |-> !sda_oe) else $error("answer while programming");
	// A Stop that launches programming also drops standby, so only a wake with no cycle running needs a Start.
	start_wake_a: assert property ($fell(standby) && !prog_busy |-> scl_pin && !sda_i) else $error("wake without start");

	cover property ($rose(prog_busy));
	cover property ($fell(sda_oe));
	cover property ($fell(standby));
endmodule : seb_eeprom_props

bind seb_eeprom seb_eeprom_props #(.PROG_CYCLES(PROG_CYCLES)) chk_u (.bus_sample_clk(bus_sample_clk),
	.arst_n(arst_n), .scl_pin(scl_pin), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .standby(standby),
	.prog_busy(prog_busy));

// file: seb_master_model.sv
`timescale 1ns/1ps

// Two-wire bus master; the clock stands high between frames.
module seb_master_model (
	// Pacing clock.
	input wire logic clk,
	// Resolved data wire.
	input wire logic sda_w,
	// Clock and data drive, high means released.
	output logic     scl,
	output logic     sda
);
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end

	// Five core edges keep every phase above four link samples.
	task automatic ph();
		repeat (5) @(negedge clk);
	endtask : ph

	task automatic start();
		sda = 1'b1;
		ph();
		scl = 1'b1;
		ph();
		sda = 1'b0;
		ph();
		scl = 1'b0;
		ph();
	endtask : start

	task automatic stop();
		sda = 1'b0;
		ph();
		scl = 1'b1;
		ph();
		sda = 1'b1;
		ph();
	endtask : stop

	// Data moves only while the clock is low, so no false start or stop.
	task automatic bit_io(input logic b, output logic r);
		sda = b;
		ph();
		scl = 1'b1;
		ph();
		r = sda_w;
		scl = 1'b0;
		ph();
	endtask : bit_io

	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(mack, ack);
	endtask : xfer
endmodule : seb_master_model

// file: tb_seb_eeprom.sv
`timescale 1ns/1ps

module tb_seb_eeprom;
	localparam logic [3:0] TYPE = 4'h6; // Arbitrary device-type nibble.
	logic       ref_clk        = 1'b0;
	logic       bus_sample_clk = 1'b0;
	logic       arst_n         = 1'b0;
	logic       wp_pin         = 1'b0;
	logic       scl, m_sda, sda_o, sda_oe, standby, prog_busy, sda_w, ack;
	logic [7:0] rx;
	logic [7:0] mem [2048];
	int         error_cnt      = 0;
	int         check_count    = 0;

	// Pull-up wire, low while either party pulls it.
	assign sda_w = m_sda & ~(sda_oe & ~sda_o);

	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end
	// Link clock with its own phase.
	initial
	begin
		#1.3;
		forever #3 bus_sample_clk = ~bus_sample_clk;
	end

	seb_eeprom #(.TYPE_CODE(TYPE), .PROG_CYCLES(200)) dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
		.bus_sample_clk(bus_sample_clk), .scl_pin(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
		.wp_pin(wp_pin), .standby(standby), .prog_busy(prog_busy));
	seb_master_model m_u (.clk(ref_clk), .sda_w(sda_w), .scl(scl), .sda(m_sda));

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : end_of_test

	// Bounded wait for programming to end; the wait stands in for the fixed write time.
	// master waits before next write.
	task automatic wait_idle();
		int n;
		n = 0;
		while (prog_busy !== 1'b0 && n < 4000)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 4000)
		begin
			error_cnt++;
			end_of_test();
		end
		repeat (2) @(negedge ref_clk);
		chk("standby", standby, 1'b1);
	endtask : wait_idle

	task automatic addr(input logic [2:0] blk, input logic rd);
		m_u.start();
		m_u.xfer({TYPE, blk, rd}, 1'b1, rx, ack);
	endtask : addr

	// Write n random bytes; the model page keeps the same in-page wrap.
	task automatic wr(input logic [10:0] a, input int n, input logic dack);
		logic [7:0] d;
		addr(a[10:8], 1'b0);
		chk("addr ack", ack, 1'b0);
		m_u.xfer(a[7:0], 1'b1, rx, ack);
		chk("word ack", ack, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			d = $urandom;
			m_u.xfer(d, 1'b1, rx, ack);
			chk("data ack", ack, dack);
			if (!dack)
				mem[{a[10:4], a[3:0] + i[3:0]}] = d;
		end
		m_u.stop();
	endtask : wr

	task automatic rd(input logic [10:0] p, input int n);
		for (int i = 0; i < n; i++)
		begin
			m_u.xfer(8'hff, i == n - 1, rx, ack);
			chk("read data", rx, mem[p + i[10:0]]);
		end
		m_u.stop();
	endtask : rd

	// Cuts a hang short.
	initial
	begin
		#600000;
		error_cnt++;
		end_of_test();
	end

	initial
	begin
		void'($urandom(96));
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		arst_n = 1'b1;
		repeat (8) @(negedge ref_clk);
		chk("standby", standby, 1'b1);
		m_u.start();
		m_u.xfer({~TYPE, 4'h0}, 1'b1, rx, ack);
		chk("foreign ack", ack, 1'b1);
		m_u.stop();
		wr(11'h000, 1, 1'b0);
		chk("busy", prog_busy, 1'b1);
		addr(3'h0, 1'b0);
		chk("poll busy", ack, 1'b1);
		m_u.stop();
		wait_idle();
		addr(3'h0, 1'b0);
		chk("poll done", ack, 1'b0);
		m_u.stop();
		// Eighteen bytes from the page end wrap inside the top page.
		wr(11'h7fe, 18, 1'b0);
		wait_idle();
		addr(3'h7, 1'b1);
		chk("read ack", ack, 1'b0);
		rd(11'h7f0, 1);
		// Abort a started address, then a random read across the array top.
		m_u.start();
		repeat (3) m_u.bit_io(1'b1, ack);
		addr(3'h7, 1'b0);
		m_u.xfer(8'hff, 1'b1, rx, ack);
		addr(3'h7, 1'b1);
		rd(11'h7ff, 2);
		wp_pin = 1'b1;
		wr(11'h000, 1, 1'b1);
		chk("wp busy", prog_busy, 1'b0);
		wp_pin = 1'b0;
		addr(3'h0, 1'b0);
		m_u.xfer(8'h00, 1'b1, rx, ack);
		addr(3'h0, 1'b1);
		rd(11'h000, 1);
		end_of_test();
	end
endmodule : tb_seb_eeprom
